// file: inc/erw_pkg.sv
package erw_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CFG    = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_CMD    = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RDATA  = 8'h14;
    // configuration field positions
    localparam int CFG_RDY_EN   = 0;
    localparam int CFG_RDY_HIGH = 1;
    localparam int CFG_RDY_ASYN = 2;
    localparam int CFG_MUX      = 3;
    localparam int CFG_AB_TWO   = 4;
    localparam int CFG_AB_EXT   = 5;  // 2 bits
    localparam int CFG_CMD_DLY  = 7;  // 2 bits
    localparam int CFG_DS_LEN   = 9;
    localparam int CFG_ACC_M1   = 10; // 5 bits, access phase length minus one
    localparam int CFG_HOLD     = 15; // 2 bits
    localparam int CFG_W        = 17;
    // command and status bits
    localparam int CMD_GO    = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_HIGH  = 2;
    localparam int ST_BUSY   = 0;
    localparam int ST_DONE   = 1;
    // reset values
    localparam logic [CFG_W-1:0] CFG_RST = 17'h00000;
    // bus cycle phases
    typedef enum logic [2:0] {
        erw_idle, erw_addr, erw_cmdd, erw_dset, erw_acc, erw_rdyw, erw_hold
    } erw_phase_e;
endpackage : erw_pkg

// file: core/erw_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - ready input can stretch each cycle; active level is configurable
// - synchronous ready allows shortest cycle; partner drives it on our clock
// - asynchronous ready goes through a synchronizer, adding at least one waitstate
// - first sampling point follows programmed phases; differs sync versus async
// - ready inactive adds one waitstate; ready active ends the cycle
// - mandatory access waitstates finish before ready is looked at
// - read data captured on the edge that raises the strobe
// - mux mode shares address and write data; separate_bus_mode uses data lines
// - address phase one or two periods plus zero to three on window change
module erw_ctrl
    import erw_pkg::*;
(
    // system side
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external bus, clocked by the link clock
    input  wire logic        bus_clk,
    output logic             clock_output_reference,
    output logic [23:0]      addr_lines,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic             ale,
    output logic             high_byte_enable_n,
    input  wire logic [15:0] shared_bus_lines_i,
    output logic      [15:0] shared_bus_lines_o,
    output logic             shared_bus_lines_oe,
    input  wire logic [15:0] data_lines_i,
    output logic      [15:0] data_lines_o,
    output logic             data_lines_oe,
    input  wire logic        ready_in
);
    // ---------------- system domain ----------------
    logic [CFG_W-1:0] cfg, next_cfg;
    logic [23:0]      addr, next_addr;
    logic [15:0]      wdata, next_wdata, rdata, next_rdata;
    logic             wr, next_wr, hbe, next_hbe;
    logic             busy, next_busy, done, next_done;
    logic             req_tgl, next_req_tgl;
    logic [31:0]      next_prdata;
    logic             perr, next_perr;
    logic [2:0]       ack_s, next_ack_s;
    logic             ack_seen, next_ack_seen;
    logic             ack_ev, wen, ren, hit;
    // bus-domain state read across
    logic             done_tgl;
    logic [15:0]      rdata_b;

    assign clock_output_reference = bus_clk; // forwarded reference for sync ready
    assign pready  = 1'b1;                   // zero wait: answer in first access cycle
    assign pslverr = psel & penable & perr;
    // done toggle from link side: counts once second and third stage agree
    assign ack_ev = (ack_s[1] == ack_s[2]) && (ack_s[2] != ack_seen);
    assign wen    = psel & penable & pwrite;
    assign ren    = psel & ~penable;
    assign hit    = (paddr == OFS_CFG) || (paddr == OFS_ADDR) || (paddr == OFS_WDATA) ||
                    (paddr == OFS_CMD) || (paddr == OFS_STATUS) || (paddr == OFS_RDATA);

    // register file; setup registers freeze while a cycle runs so the crossing stays clean
    always_comb begin
        next_cfg      = cfg;
        next_addr     = addr;
        next_wdata    = wdata;
        next_wr       = wr;
        next_hbe      = hbe;
        next_busy     = busy;
        next_done     = done;
        next_req_tgl  = req_tgl;
        next_rdata    = rdata;
        next_ack_s    = {ack_s[1:0], done_tgl};
        next_ack_seen = ack_seen;
        next_prdata   = prdata;
        next_perr     = perr;
        if (ren) begin
            next_perr   = ~hit;
            next_prdata = 32'h00000000;
            case (paddr)
                OFS_CFG:    next_prdata = {15'h0000, cfg};
                OFS_ADDR:   next_prdata = {8'h00, addr};
                OFS_WDATA:  next_prdata = {16'h0000, wdata};
                OFS_CMD:    next_prdata = {29'h00000000, hbe, wr, 1'b0};
                OFS_STATUS: next_prdata = {30'h00000000, done, busy};
                OFS_RDATA:  next_prdata = {16'h0000, rdata};
                default:    next_prdata = 32'h00000000;
            endcase
        end
        if (wen && !busy) begin
            case (paddr)
                OFS_CFG:   next_cfg   = pwdata[CFG_W-1:0];
                OFS_ADDR:  next_addr  = pwdata[23:0];
                OFS_WDATA: next_wdata = pwdata[15:0];
                OFS_CMD: begin
                    next_wr  = pwdata[CMD_WRITE];
                    next_hbe = pwdata[CMD_HIGH];
                    if (pwdata[CMD_GO]) begin
                        next_busy    = 1'b1;
                        next_done    = 1'b0;
                        next_req_tgl = ~req_tgl;
                    end
                end
                default: ;
            endcase
        end
        if (ack_ev) begin
            next_ack_seen = ack_s[2];
            next_busy     = 1'b0;
            next_done     = 1'b1; // completion wins over any clear in the same cycle
            next_rdata    = rdata_b;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg      <= CFG_RST;
            addr     <= 24'h000000;
            wdata    <= 16'h0000;
            wr       <= 1'b0;
            hbe      <= 1'b0;
            busy     <= 1'b0;
            done     <= 1'b0;
            req_tgl  <= 1'b0;
            rdata    <= 16'h0000;
            ack_s    <= 3'h0;
            ack_seen <= 1'b0;
            prdata   <= 32'h00000000;
            perr     <= 1'b0;
        end else begin
            cfg      <= next_cfg;
            addr     <= next_addr;
            wdata    <= next_wdata;
            wr       <= next_wr;
            hbe      <= next_hbe;
            busy     <= next_busy;
            done     <= next_done;
            req_tgl  <= next_req_tgl;
            rdata    <= next_rdata;
            ack_s    <= next_ack_s;
            ack_seen <= next_ack_seen;
            prdata   <= next_prdata;
            perr     <= next_perr;
        end
    end

    // ---------------- link domain ----------------
    logic [1:0]       rst_s;
    logic             brst;
    logic [2:0]       req_s, rdy_s;
    logic             req_seen, next_req_seen, rdy_flt, next_rdy_flt;
    logic             req_ev;
    erw_phase_e       ph, next_ph;
    logic [4:0]       cnt, next_cnt;
    logic [CFG_W-1:0] bcfg, next_bcfg;
    logic [7:0]       last_win, next_last_win;
    logic [23:0]      next_addr_lines;
    logic             next_cs_n, next_rd_n, next_wr_n, next_ale, next_hbe_n;
    logic [15:0]      next_sh_o, next_dl_o, next_rdata_b;
    logic             next_sh_oe, next_dl_oe, next_done_tgl;
    logic             bwr, next_bwr, rdy_act, ends;
    logic [15:0]      bwd, next_bwd;

    // reset follows into the link domain through two stages
    always_ff @(posedge bus_clk) begin
        rst_s <= {rst_s[0], srst};
    end
    assign brst = rst_s[1];

    // request toggle and async ready both pass three stages; a change counts on 2/3 agree
    assign req_ev = (req_s[1] == req_s[2]) && (req_s[2] != req_seen);
    // sync mode samples the pin directly: it is timed to our own reference clock
    assign rdy_act = bcfg[CFG_RDY_ASYN] ? (rdy_flt == bcfg[CFG_RDY_HIGH])
                                        : (ready_in == bcfg[CFG_RDY_HIGH]);

    // length helpers: count loaded is phase length minus one
    function automatic erw_phase_e after_addr(input logic [CFG_W-1:0] c);
        if (c[CFG_CMD_DLY+:2] != 2'h0) after_addr = erw_cmdd;
        else if (c[CFG_DS_LEN])        after_addr = erw_dset;
        else                           after_addr = erw_acc;
    endfunction : after_addr

    function automatic logic [4:0] len_of(input erw_phase_e p, input logic [CFG_W-1:0] c);
        case (p)
            erw_cmdd: len_of = {3'h0, c[CFG_CMD_DLY+:2]} - 5'h01;
            erw_acc:  len_of = c[CFG_ACC_M1+:5];
            erw_hold: len_of = {3'h0, c[CFG_HOLD+:2]} - 5'h01;
            default:  len_of = 5'h00;
        endcase
    endfunction : len_of

    // bus cycle engine; outputs are registered so they change only on link edges
    always_comb begin
        next_ph         = ph;
        next_cnt        = cnt;
        next_bcfg       = bcfg;
        next_last_win   = last_win;
        next_req_seen   = req_seen;
        next_rdy_flt    = (rdy_s[1] == rdy_s[2]) ? rdy_s[2] : rdy_flt;
        next_addr_lines = addr_lines;
        next_cs_n       = cs_n;
        next_rd_n       = rd_n;
        next_wr_n       = wr_n;
        next_ale        = ale;
        next_hbe_n      = high_byte_enable_n;
        next_sh_o       = shared_bus_lines_o;
        next_sh_oe      = shared_bus_lines_oe;
        next_dl_o       = data_lines_o;
        next_dl_oe      = data_lines_oe;
        next_rdata_b    = rdata_b;
        next_done_tgl   = done_tgl;
        next_bwr        = bwr;
        next_bwd        = bwd;
        ends            = 1'b0;
        case (ph)
            erw_idle: if (req_ev) begin
                next_req_seen   = req_s[2];
                next_bcfg       = cfg;
                next_bwr        = wr;
                next_bwd        = wdata;
                next_last_win   = addr[23:16];
                next_cnt        = {4'h0, cfg[CFG_AB_TWO]} +
                                  ((addr[23:16] != last_win) ? {3'h0, cfg[CFG_AB_EXT+:2]} : 5'h00);
                next_ph         = erw_addr;
                next_addr_lines = addr;
                next_cs_n       = 1'b0;
                next_hbe_n      = ~hbe;
                next_ale        = cfg[CFG_MUX];
                next_sh_o       = addr[15:0];
                next_sh_oe      = cfg[CFG_MUX];
            end
            erw_addr, erw_cmdd, erw_dset: if (cnt == 5'h00) begin
                next_ale = 1'b0;
                // write data goes out once the address phase is over
                next_sh_oe = bcfg[CFG_MUX] & bwr;
                next_sh_o  = bwd;
                next_dl_oe = ~bcfg[CFG_MUX] & bwr;
                next_dl_o  = bwd;
                if (ph == erw_addr) next_ph = after_addr(bcfg);
                else if (ph == erw_cmdd && bcfg[CFG_DS_LEN]) next_ph = erw_dset;
                else next_ph = erw_acc;
                next_cnt = len_of(next_ph, bcfg);
                if (next_ph == erw_acc) begin
                    next_rd_n = bwr;
                    next_wr_n = ~bwr;
                end
            end else begin
                next_cnt = cnt - 5'h01;
            end
            erw_acc: if (cnt != 5'h00) begin
                next_cnt = cnt - 5'h01;
            end else if (!bcfg[CFG_RDY_EN]) begin
                ends = 1'b1;
            end else if (!bcfg[CFG_RDY_ASYN] && rdy_act) begin
                ends = 1'b1;
            end else begin
                next_ph = erw_rdyw;  // async always waits once for its synchronizer
            end
            erw_rdyw: if (rdy_act) begin
                ends = 1'b1;
            end
            erw_hold: if (cnt == 5'h00) begin
                next_ph = erw_idle;
            end else begin
                next_cnt = cnt - 5'h01;
            end
            default: next_ph = erw_idle;
        endcase
        // cycle end: strobes rise and read data is latched on this same edge
        if (ends) begin
            next_rd_n    = 1'b1;
            next_wr_n    = 1'b1;
            next_rdata_b = bcfg[CFG_MUX] ? shared_bus_lines_i : data_lines_i;
            next_ph      = (bcfg[CFG_HOLD+:2] != 2'h0) ? erw_hold : erw_idle;
            next_cnt     = len_of(erw_hold, bcfg);
        end
        if (next_ph == erw_idle && ph != erw_idle) begin
            next_cs_n     = 1'b1;
            next_hbe_n    = 1'b1;
            next_sh_oe    = 1'b0;
            next_dl_oe    = 1'b0;
            next_done_tgl = ~done_tgl;
        end
    end

    always_ff @(posedge bus_clk) begin
        req_s <= {req_s[1:0], req_tgl};
        rdy_s <= {rdy_s[1:0], ready_in};
        if (brst) begin
            ph                  <= erw_idle;
            cnt                 <= 5'h00;
            bcfg                <= CFG_RST;
            last_win            <= 8'h00;
            req_seen            <= 1'b0;
            rdy_flt             <= 1'b0;
            addr_lines          <= 24'h000000;
            cs_n                <= 1'b1;
            rd_n                <= 1'b1;
            wr_n                <= 1'b1;
            ale                 <= 1'b0;
            high_byte_enable_n  <= 1'b1;
            shared_bus_lines_o  <= 16'h0000;
            shared_bus_lines_oe <= 1'b0;
            data_lines_o        <= 16'h0000;
            data_lines_oe       <= 1'b0;
            rdata_b             <= 16'h0000;
            done_tgl            <= 1'b0;
            bwr                 <= 1'b0;
            bwd                 <= 16'h0000;
        end else begin
            ph                  <= next_ph;
            cnt                 <= next_cnt;
            bcfg                <= next_bcfg;
            last_win            <= next_last_win;
            req_seen            <= next_req_seen;
            rdy_flt             <= next_rdy_flt;
            addr_lines          <= next_addr_lines;
            cs_n                <= next_cs_n;
            rd_n                <= next_rd_n;
            wr_n                <= next_wr_n;
            ale                 <= next_ale;
            high_byte_enable_n  <= next_hbe_n;
            shared_bus_lines_o  <= next_sh_o;
            shared_bus_lines_oe <= next_sh_oe;
            data_lines_o        <= next_dl_o;
            data_lines_oe       <= next_dl_oe;
            rdata_b             <= next_rdata_b;
            done_tgl            <= next_done_tgl;
            bwr                 <= next_bwr;
            bwd                 <= next_bwd;
        end
    end
endmodule : erw_ctrl

// file: sim/erw_ctrl_asserts.sv
`timescale 1ns/1ps
module erw_ctrl_asserts
    import erw_pkg::*;
(
    // system side
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // external bus
    input wire logic        bus_clk,
    input wire logic [23:0] addr_lines,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        ale,
    input wire logic [15:0] shared_bus_lines_o,
    input wire logic        shared_bus_lines_oe,
    input wire logic        ready_in
);
    logic [CFG_W-1:0] cfg, next_cfg, ccfg, next_ccfg;
    logic [5:0]       slen, next_slen;
    logic             strb;
    int               acc;
    // config shadow; the bench writes it only while idle
    always_comb begin
        next_cfg = srst ? CFG_RST : cfg;
        if (psel && penable && pwrite && paddr == OFS_CFG) begin
            next_cfg = pwdata[CFG_W-1:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        cfg <= next_cfg;
    end
    // frozen while a strobe is low, so a new config cannot skew the end check
    assign strb = !(rd_n && wr_n);
    assign acc  = int'(ccfg[CFG_ACC_M1 +: 5]) + 1;
    always_comb begin
        next_slen = (strb && !srst) ? slen + 6'h01 : 6'h00;
        next_ccfg = strb ? ccfg : cfg;
    end
    always_ff @(posedge bus_clk) begin
        slen <= next_slen;
        ccfg <= next_ccfg;
    end
    property p_addr_stable;
        @(posedge bus_clk) disable iff (srst) !cs_n && !$past(cs_n) |-> $stable(addr_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");
    property p_ale_addr;
        @(posedge bus_clk) disable iff (srst)
            ale |-> shared_bus_lines_oe && shared_bus_lines_o == addr_lines[15:0];
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("bad mux address");
    property p_strobe_cs;
        @(posedge bus_clk) disable iff (srst) strb |-> !cs_n && (rd_n || wr_n);
    endproperty
    a_strobe_cs: assert property (p_strobe_cs) else $error("strobe outside select");
    property p_acc_min;
        @(posedge bus_clk) disable iff (srst) $fell(strb) |-> slen >= acc;
    endproperty
    a_acc_min: assert property (p_acc_min) else $error("access too short");
    property p_fixed_len;
        @(posedge bus_clk) disable iff (srst) $fell(strb) && !ccfg[CFG_RDY_EN] |-> slen == acc;
    endproperty
    a_fixed_len: assert property (p_fixed_len) else $error("bad fixed length");
    property p_sync_end;
        @(posedge bus_clk) disable iff (srst) strb && ccfg[CFG_RDY_EN] && !ccfg[CFG_RDY_ASYN]
            && slen + 1 >= acc && ready_in == ccfg[CFG_RDY_HIGH] |=> !strb;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("ready ignored");
    property p_sync_wait;
        @(posedge bus_clk) disable iff (srst) strb && ccfg[CFG_RDY_EN] && !ccfg[CFG_RDY_ASYN]
            && ready_in != ccfg[CFG_RDY_HIGH] |=> strb;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("ended not ready");
    property p_async_min;
        @(posedge bus_clk) disable iff (srst)
            $fell(strb) && ccfg[CFG_RDY_EN] && ccfg[CFG_RDY_ASYN] |-> slen > acc;
    endproperty
    a_async_min: assert property (p_async_min) else $error("no async wait");
endmodule : erw_ctrl_asserts
bind erw_ctrl erw_ctrl_asserts i_erw_ctrl_asserts (.sys_clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .bus_clk, .addr_lines, .cs_n, .rd_n, .wr_n, .ale,
    .shared_bus_lines_o, .shared_bus_lines_oe, .ready_in);

// file: sim/erw_ext_mem.sv
`timescale 1ns/1ps
module erw_ext_mem (
    // link side
    input  wire logic        bus_clk,
    input  wire logic [23:0] addr_lines,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] wdata,
    // ready behaviour
    input  wire logic [3:0]  rdy_wait,
    input  wire logic        rdy_high,
    output logic             ready_in,
    output logic      [15:0] rd_word
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [3:0]  cnt  = 4'h0;
    logic        strb;
    assign strb = !(rd_n && wr_n);
    // held until the strobe rises, then dropped at once
    assign ready_in = (strb && cnt >= rdy_wait) ~^ rdy_high;
    // released lines show the inverse, so stale data cannot pass
    assign rd_word = !rd_n ? mem[addr_lines[3:0]] : ~last;
    always @(posedge bus_clk) begin
        cnt <= strb ? cnt + 4'h1 : 4'h0;
        if (!rd_n) last <= mem[addr_lines[3:0]];
        if (!wr_n) mem[addr_lines[3:0]] <= wdata;
    end
endmodule : erw_ext_mem

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import erw_pkg::*;
    logic        sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, bus_clk = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, clock_output_reference, cs_n, rd_n, wr_n, ale, hbe_n, er;
    logic [23:0] addr_lines;
    logic [15:0] sh_i, sh_o, dl_i, dl_o, rd_word;
    logic        sh_oe, dl_oe, ready_in, p_high = 0;
    logic [3:0]  p_wait = 4'h0;
    int          n_fail = 0, check_count = 0, tb_len = 0, run_len = 0;
    int          cs_run = 0, cs_len = 0, ref_n = 0, bus_n = 0;
    logic        hbe_seen = 1'b1;
    logic [7:0]  win = 8'h00;
    initial forever #2.5 sys_clk = !sys_clk;
    initial begin
        #37;
        forever #80 bus_clk = !bus_clk;
    end
    // wire level: an enabled driver wins, otherwise the memory
    assign sh_i = sh_oe ? sh_o : rd_word;
    assign dl_i = dl_oe ? dl_o : rd_word;
    erw_ctrl i_erw_ctrl (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bus_clk, .clock_output_reference, .addr_lines, .cs_n, .rd_n,
        .wr_n, .ale, .high_byte_enable_n(hbe_n), .shared_bus_lines_i(sh_i),
        .shared_bus_lines_o(sh_o), .shared_bus_lines_oe(sh_oe), .data_lines_i(dl_i),
        .data_lines_o(dl_o), .data_lines_oe(dl_oe), .ready_in);
    erw_ext_mem i_erw_ext_mem (.bus_clk, .addr_lines, .rd_n, .wr_n,
        .wdata(sh_oe ? sh_i : dl_i), .rdy_wait(p_wait), .rdy_high(p_high), .ready_in, .rd_word);
    // strobe-low length of the running cycle, in link periods
    always @(posedge bus_clk) begin
        if (!rd_n || !wr_n) begin
            run_len <= run_len + 1;
            tb_len <= run_len + 1;
        end
        else run_len <= 0;
        // select-low length and byte enable of the running cycle
        if (!cs_n) begin
            cs_run <= cs_run + 1;
            cs_len <= cs_run + 1;
            hbe_seen <= hbe_n;
        end else begin
            cs_run <= 0;
        end
        bus_n <= bus_n + 1;
    end
    // reference edges counted apart, so a stuck or gated reference shows up
    always @(posedge clock_output_reference) begin
        ref_n <= ref_n + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // flags are {mux, async, active high, ready enable}
    function automatic logic [31:0] cfg(input logic [3:0] f, input logic [4:0] am1);
        cfg = {17'h00000, am1, 6'h00, f};
    endfunction : cfg
    task automatic run_case(input logic [31:0] c, input logic wr, input logic [23:0] adr,
        input logic [15:0] dat, input logic [3:0] w, input logic hi, input int lo, input int up);
        int n, ab;
        // select-only periods: address phase, command delay, data setup, hold
        ab = 1 + c[CFG_AB_TWO] + c[CFG_CMD_DLY+:2] + c[CFG_DS_LEN] + c[CFG_HOLD+:2] +
             ((adr[23:16] != win) ? c[CFG_AB_EXT+:2] : 0);
        win = adr[23:16];
        p_wait <= w;
        p_high <= hi;
        apb(1'b1, OFS_CFG, c);
        apb(1'b1, OFS_ADDR, {8'h00, adr});
        apb(1'b1, OFS_WDATA, {16'h0000, dat});
        apb(1'b1, OFS_CMD, {29'h0, adr[0], wr, 1'b1});
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd !== 32'h2 && n < 2000);
        check("status", rd, 32'h2);
        check("strobe length", 32'(tb_len >= lo && tb_len <= up), 32'h1);
        check("select length", cs_len - tb_len, ab);
        check("high byte enable", {31'h0, hbe_seen}, {31'h0, ~adr[0]});
        check("reference edges", ref_n, bus_n);
        if (!wr) begin
            apb(1'b0, OFS_RDATA, 32'h0);
            check("read data", rd, {16'h0000, dat});
        end
        $display("test done: cfg %h length %0d", c, tb_len);
    endtask : run_case
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge bus_clk);
        srst <= 1'b0;
        repeat (4) @(posedge bus_clk);
        @(posedge sys_clk);
        apb(1'b0, OFS_CFG, 32'h0);
        check("cfg reset", rd, {15'h0000, CFG_RST});
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", {31'h0, er}, 32'h1);
        $display("test done: reset and map");
        run_case(cfg(4'h0, 5'h02), 1'b1, 24'h010003, 16'hA5C3, 4'h0, 1'b0, 3, 3);
        run_case(cfg(4'h8, 5'h00), 1'b0, 24'h010003, 16'hA5C3, 4'h0, 1'b0, 1, 1);
        run_case(cfg(4'hB, 5'h01), 1'b1, 24'h020005, 16'h3C5A, 4'h0, 1'b1, 2, 2);
        run_case(cfg(4'h1, 5'h00), 1'b0, 24'h020005, 16'h3C5A, 4'h3, 1'b0, 4, 4);
        run_case(cfg(4'hF, 5'h00), 1'b0, 24'h010003, 16'hA5C3, 4'h0, 1'b1, 2, 8);
        run_case(cfg(4'h5, 5'h01), 1'b1, 24'h03000C, 16'h0FF0, 4'h2, 1'b0, 3, 10);
        run_case(cfg(4'h8, 5'h1F), 1'b0, 24'h03000C, 16'h0FF0, 4'h0, 1'b0, 32, 32);
        // two-period address, window extension on the write only, command delay, data setup and hold
        run_case(32'h000106D8, 1'b1, 24'h04000A, 16'h5AA5, 4'h0, 1'b0, 2, 2);
        run_case(32'h000106D8, 1'b0, 24'h04000A, 16'h5AA5, 4'h0, 1'b0, 2, 2);
        end_of_test();
    end
endmodule : testbench
